// file: sdac_src.sv
// Purpose: Audio source and mode controller driving the DAC link
// Assumes: Register port master per house bus, 20 MHz ref_clk
// Notes:   Bit clock and oscillator are divided from ref_clk
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps
module sdac_src
  import sdac_pkg::*;
(
  // System
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Link
  sdac_if.src              link,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq
);
  typedef enum logic [3:0] {
    SC_IDLE  = 4'b0001,
    SC_LOW   = 4'b0010,
    SC_HIGH  = 4'b0100,
    SC_LATCH = 4'b1000
  } sdac_cs_t;

  logic [7:0]  ctrl_reg, ctrl_next;
  logic [17:0] left_reg, left_next, right_reg, right_next;
  logic [17:0] lw_reg, lw_next, rw_reg, rw_next;
  logic [2:0]  mask_reg, mask_next, stat_reg, stat_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        irq_reg, irq_next;
  logic [7:0]  div_reg, div_next, odiv_reg, odiv_next;
  logic        osc_reg, osc_next, bck_reg, bck_next, lrck_reg, lrck_next;
  logic        dat_reg, dat_next, half_reg, half_next;
  logic [4:0]  slot_reg, slot_next;
  logic [15:0] cmd_reg, cmd_next;
  logic        cmd_pend_reg, cmd_pend_next;
  logic [3:0]  cbit_reg, cbit_next;
  sdac_cs_t    cs_reg, cs_next;
  logic        p0_reg, p0_next, p1_reg, p1_next, p2_reg, p2_next;
  logic        sil_s1_reg, sil_s2_reg, sil_prev_reg;
  logic        tick;
  logic [2:0]  ev;

  // MSB-first bit for a slot; unused slots carry zero
  function automatic logic slot_bit(input logic [17:0] w, input logic [4:0] s,
                                    input logic i2s, input logic w18);
    logic [5:0] n;
    logic [5:0] p;
    n = w18 ? 6'(WORD_LONG) : 6'(WORD_SHORT);
    p = i2s ? (6'(s) - 6'd1) : (6'(s) - (6'(SLOTS_PER_HALF) - n));
    if (i2s ? (s == 5'd0 || p >= n) : (6'(s) < 6'(SLOTS_PER_HALF) - n))
      slot_bit = 1'b0;
    else
      slot_bit = w[5'(n - 6'd1 - p)];
  endfunction

  assign tick = (div_reg == 8'(BCK_HALF_CYC - 1));

  always_comb begin
    ctrl_next  = ctrl_reg;
    left_next  = left_reg;
    right_next = right_reg;
    mask_next  = mask_reg;
    cmd_next   = cmd_reg;
    cmd_pend_next = cmd_pend_reg;
    rdata_next = 32'h0000_0000;
    div_next   = tick ? 8'h00 : div_reg + 8'h01;
    odiv_next  = (odiv_reg == 8'(OSC_HALF_CYC - 1)) ? 8'h00 : odiv_reg + 8'h01;
    osc_next   = (odiv_reg == 8'(OSC_HALF_CYC - 1)) ? ~osc_reg : osc_reg;
    bck_next   = bck_reg;
    lrck_next  = lrck_reg;
    dat_next   = dat_reg;
    half_next  = half_reg;
    slot_next  = slot_reg;
    lw_next    = lw_reg;
    rw_next    = rw_reg;
    cs_next    = cs_reg;
    cbit_next  = cbit_reg;
    ev         = 3'h0;
    ev[ST_SILENCE] = sil_prev_reg & ~sil_s2_reg;
    // Register writes
    if (reg_wr) begin
      if (reg_addr == ADDR_CTRL) begin
        ctrl_next = reg_wdata[7:0];
      end else if (reg_addr == ADDR_LEFT) begin
        left_next = reg_wdata[17:0];
      end else if (reg_addr == ADDR_RIGHT) begin
        right_next = reg_wdata[17:0];
      end else if (reg_addr == ADDR_CMD && !cmd_pend_reg) begin
        cmd_next      = reg_wdata[15:0];
        cmd_pend_next = 1'b1;
      end else if (reg_addr == ADDR_MASK) begin
        mask_next = reg_wdata[2:0];
      end
    end
    // Bit clock and frame; data and frame clock move on the falling edge
    if (tick && ctrl_reg[CTRL_RUN]) begin
      bck_next = ~bck_reg;
      if (bck_reg) begin
        slot_next = slot_reg + 5'd1;
        half_next = (slot_reg == 5'(SLOTS_PER_HALF - 1)) ? ~half_reg : half_reg;
        if (slot_next == 5'd0 && !half_next) begin
          lw_next = left_reg;
          rw_next = right_reg;
          ev[ST_FRAME] = 1'b1;
        end
        lrck_next = ctrl_reg[CTRL_I2S] ? half_next : ~half_next;
        dat_next  = slot_bit(half_next ? rw_next : lw_next, slot_next,
                             ctrl_reg[CTRL_I2S], ctrl_reg[CTRL_LEN18]);
      end
    end
    // Stopping restarts the frame, so a restart never sends a short half
    if (!ctrl_reg[CTRL_RUN]) begin
      slot_next = 5'h1F;
      half_next = 1'b1;
    end
    // Control word shifter
    p0_next = ctrl_reg[CTRL_DM0];
    p1_next = ctrl_reg[CTRL_DM1];
    p2_next = ~ctrl_reg[CTRL_MUTE];
    if (tick) begin
      case (cs_reg)
        SC_IDLE: begin
          cbit_next = 4'h0;
          if (cmd_pend_reg && ctrl_reg[CTRL_SWMODE])
            cs_next = SC_LOW;
        end
        SC_LOW: begin
          cs_next = SC_HIGH;
        end
        SC_HIGH: begin
          cmd_next  = {cmd_reg[14:0], 1'b0};
          cbit_next = cbit_reg + 4'h1;
          cs_next   = (cbit_reg == 4'(CW_BITS - 1)) ? SC_LATCH : SC_LOW;
        end
        SC_LATCH: begin
          cs_next       = SC_IDLE;
          cmd_pend_next = 1'b0;
          ev[ST_CMD]    = 1'b1;
        end
        default: cs_next = SC_IDLE;
      endcase
    end
    if (ctrl_reg[CTRL_SWMODE]) begin
      p0_next = cmd_reg[15];
      p1_next = (cs_next == SC_HIGH);
      p2_next = (cs_next == SC_LATCH);
    end
    // Reads; a status read clears the event bits it returned, new events still land
    stat_next = stat_reg | ev;
    if (reg_rd) begin
      if (reg_addr == ADDR_CTRL) begin
        rdata_next = {24'h00_0000, ctrl_reg};
      end else if (reg_addr == ADDR_LEFT) begin
        rdata_next = {14'h0000, left_reg};
      end else if (reg_addr == ADDR_RIGHT) begin
        rdata_next = {14'h0000, right_reg};
      end else if (reg_addr == ADDR_CMD) begin
        rdata_next = {16'h0000, cmd_reg};
      end else if (reg_addr == ADDR_STATUS) begin
        rdata_next = {28'h000_0000, cmd_pend_reg, stat_reg};
        stat_next  = (stat_reg & ~stat_reg) | ev;
      end else if (reg_addr == ADDR_MASK) begin
        rdata_next = {29'h0000_0000, mask_reg};
      end
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg     <= CTRL_RST;
      left_reg     <= WORD_RST;
      right_reg    <= WORD_RST;
      lw_reg       <= WORD_RST;
      rw_reg       <= WORD_RST;
      mask_reg     <= MASK_RST;
      stat_reg     <= 3'h0;
      rdata_reg    <= 32'h0000_0000;
      irq_reg      <= 1'b0;
      div_reg      <= 8'h00;
      odiv_reg     <= 8'h00;
      osc_reg      <= 1'b0;
      bck_reg      <= 1'b0;
      lrck_reg     <= 1'b0;
      dat_reg      <= 1'b0;
      half_reg     <= 1'b1;
      slot_reg     <= 5'h1F;
      cmd_reg      <= 16'h0000;
      cmd_pend_reg <= 1'b0;
      cbit_reg     <= 4'h0;
      cs_reg       <= SC_IDLE;
      p0_reg       <= 1'b0;
      p1_reg       <= 1'b0;
      p2_reg       <= 1'b1;
      sil_s1_reg   <= 1'b1;
      sil_s2_reg   <= 1'b1;
      sil_prev_reg <= 1'b1;
    end else begin
      ctrl_reg     <= ctrl_next;
      left_reg     <= left_next;
      right_reg    <= right_next;
      lw_reg       <= lw_next;
      rw_reg       <= rw_next;
      mask_reg     <= mask_next;
      stat_reg     <= stat_next;
      rdata_reg    <= rdata_next;
      irq_reg      <= irq_next;
      div_reg      <= div_next;
      odiv_reg     <= odiv_next;
      osc_reg      <= osc_next;
      bck_reg      <= bck_next;
      lrck_reg     <= lrck_next;
      dat_reg      <= dat_next;
      half_reg     <= half_next;
      slot_reg     <= slot_next;
      cmd_reg      <= cmd_next;
      cmd_pend_reg <= cmd_pend_next;
      cbit_reg     <= cbit_next;
      cs_reg       <= cs_next;
      p0_reg       <= p0_next;
      p1_reg       <= p1_next;
      p2_reg       <= p2_next;
      sil_s1_reg   <= link.silence_line;
      sil_s2_reg   <= sil_s1_reg;
      sil_prev_reg <= sil_s2_reg;
    end
  end

  assign link.bit_clock_in      = bck_reg;
  assign link.frame_sync_clock  = lrck_reg;
  assign link.audio_data        = dat_reg;
  assign link.osc_in            = osc_reg;
  assign link.op_mode_sel       = ctrl_reg[CTRL_SWMODE];
  assign link.ext_reset_n       = ~ctrl_reg[CTRL_RESET];
  assign link.ctrl_data_in      = p0_reg;
  assign link.ctrl_shift_clock  = p1_reg;
  assign link.ctrl_latch_strobe = p2_reg;
  assign reg_rdata              = rdata_reg;
  assign irq                    = irq_reg;
endmodule

// file: sdac_pkg.sv
// Purpose: Shared constants for the stereo DAC serial link, both ends
// Assumes: 20 MHz ref_clk on both ends
// Notes:   Offsets and bit positions of the controller registers live here
package sdac_pkg;
  // Timing
  localparam int REF_CLK_NS    = 50;
  localparam int BCK_PERIOD_NS = 400;
  localparam int BCK_HALF_CYC  = BCK_PERIOD_NS / (2 * REF_CLK_NS);
  localparam int OSC_HALF_CYC  = 2;
  localparam int ZERO_RUN_BCK  = 65536;
  // Frame layout
  localparam int WORD_SHORT     = 16;
  localparam int WORD_LONG      = 18;
  localparam int SLOTS_PER_HALF = 32;
  // Serial control word
  localparam int        CW_BITS     = 16;
  localparam int        CW_IDX_LSB  = 8;
  localparam logic [1:0] CW_REG_DEEMPH = 2'h2;
  localparam logic [1:0] CW_REG_FMT    = 2'h3;
  localparam int        FMT_LEN18_BIT = 0;
  localparam int        FMT_I2S_BIT   = 1;
  localparam int        DM_MUTE_BIT   = 2;
  // Controller register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LEFT   = 8'h04;
  localparam logic [7:0] ADDR_RIGHT  = 8'h08;
  localparam logic [7:0] ADDR_CMD    = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;
  // Controller CTRL fields
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_I2S    = 1;
  localparam int CTRL_LEN18  = 2;
  localparam int CTRL_SWMODE = 3;
  localparam int CTRL_RESET  = 4;
  localparam int CTRL_DM0    = 5;
  localparam int CTRL_DM1    = 6;
  localparam int CTRL_MUTE   = 7;
  // Controller STATUS fields
  localparam int ST_FRAME   = 0;
  localparam int ST_CMD     = 1;
  localparam int ST_SILENCE = 2;
  localparam int ST_BUSY    = 3;
  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [2:0]  MASK_RST = 3'h0;
  localparam logic [17:0] WORD_RST = 18'h0_0000;
endpackage

// file: sdac_if.sv
// Purpose: Pin-level link between audio source/controller and DAC front end
// Assumes: Silence flag line has a pull-up when nobody drives it
// Notes:   Open-drain line resolved here from output and enable
`timescale 1ns/10ps
interface sdac_if;
  logic frame_sync_clock;
  logic bit_clock_in;
  logic audio_data;
  logic op_mode_sel;
  logic ctrl_data_in;
  logic ctrl_shift_clock;
  logic ctrl_latch_strobe;
  logic osc_in;
  logic ext_reset_n;
  logic buffered_osc_out;
  logic silence_o;
  logic silence_oe;
  logic silence_line;

  // Pull-up wins while the flag is undriven
  assign silence_line = silence_oe ? silence_o : 1'b1;

  modport dev (
    input  frame_sync_clock, bit_clock_in, audio_data, op_mode_sel,
    input  ctrl_data_in, ctrl_shift_clock, ctrl_latch_strobe, osc_in, ext_reset_n,
    output buffered_osc_out, silence_o, silence_oe
  );
  modport src (
    output frame_sync_clock, bit_clock_in, audio_data, op_mode_sel,
    output ctrl_data_in, ctrl_shift_clock, ctrl_latch_strobe, osc_in, ext_reset_n,
    input  buffered_osc_out, silence_line
  );
endinterface

// file: sdac_dev.sv
// Purpose: DAC digital front end: serial audio receiver and mode pins
// Assumes: All link pins asynchronous to ref_clk, bit clock well below 10 MHz
// Notes:   Every link pin passes two flops; edges found on the synced copies
`timescale 1ns/10ps
module sdac_dev
  import sdac_pkg::*;
#(
  parameter int ZERO_RUN = ZERO_RUN_BCK
)(
  // System
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Link
  sdac_if.dev              link,
  // Samples
  output logic      [17:0] left_sample,
  output logic      [17:0] right_sample,
  output logic             sample_strobe,
  // Mode
  output logic             sw_mode,
  output logic             i2s_mode,
  output logic             word_len18,
  output logic       [1:0] deemph_sel,
  output logic             mute
);
  localparam int ZW = $clog2(ZERO_RUN + 1);
  // Indices into the synchroniser vector
  localparam int I_LRCK = 8;
  localparam int I_BCK  = 7;
  localparam int I_DAT  = 6;
  localparam int I_MODE = 5;
  localparam int I_P0   = 4;
  localparam int I_P1   = 3;
  localparam int I_P2   = 2;
  localparam int I_OSC  = 1;
  localparam int I_RST  = 0;

  logic [8:0]    pins;
  logic [8:0]    s1_reg, s2_reg;
  logic [2:0]    prev_reg;
  logic          soft_rst;
  logic          bck_rise, csh_rise, lat_rise;

  logic [17:0]   shift_reg, shift_next;
  logic [5:0]    cnt_reg, cnt_next;
  logic          lr_reg, lr_next;
  logic [17:0]   lhold_reg, lhold_next;
  logic [17:0]   left_reg, left_next, right_reg, right_next;
  logic          strobe_reg, strobe_next;
  logic [ZW-1:0] zrun_reg, zrun_next;
  logic          sil_reg, sil_next;

  logic [15:0]   cw_reg, cw_next;
  logic [1:0]    fmt_reg, fmt_next;
  logic [2:0]    dm_reg, dm_next;
  logic          swm_reg, swm_next, i2s_reg, i2s_next, l18_reg, l18_next;
  logic [1:0]    de_reg, de_next;
  logic          mute_reg, mute_next, bosc_reg, bosc_next;

  logic [17:0]   nshift;
  logic [5:0]    len;
  logic          word_done, word_left;
  logic [17:0]   word;

  assign pins = {link.frame_sync_clock, link.bit_clock_in, link.audio_data,
                 link.op_mode_sel, link.ctrl_data_in, link.ctrl_shift_clock,
                 link.ctrl_latch_strobe, link.osc_in, link.ext_reset_n};

  // 16-bit words sit in the upper bits so both lengths share one scale
  function automatic logic [17:0] align(input logic w18, input logic [17:0] v);
    align = w18 ? v : {v[15:0], 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers; edge detectors read only the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Latch pin idles high; matching it avoids a false edge after reset
      s1_reg   <= 9'h005;
      s2_reg   <= 9'h005;
      prev_reg <= 3'h1;
    end else begin
      s1_reg   <= pins;
      s2_reg   <= s1_reg;
      prev_reg <= {s2_reg[I_BCK], s2_reg[I_P1], s2_reg[I_P2]};
    end
  end

  assign soft_rst = ~s2_reg[I_RST];
  assign bck_rise = s2_reg[I_BCK] & ~prev_reg[2];
  assign csh_rise = s2_reg[I_P1] & ~prev_reg[1];
  assign lat_rise = s2_reg[I_P2] & ~prev_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // Serial audio receiver and zero detector
  always_comb begin
    shift_next  = shift_reg;
    cnt_next    = cnt_reg;
    lr_next     = lr_reg;
    lhold_next  = lhold_reg;
    left_next   = left_reg;
    right_next  = right_reg;
    strobe_next = 1'b0;
    zrun_next   = zrun_reg;
    sil_next    = sil_reg;
    nshift      = {shift_reg[16:0], s2_reg[I_DAT]};
    len         = l18_reg ? 6'(WORD_LONG) : 6'(WORD_SHORT);
    word_done   = 1'b0;
    word_left   = 1'b0;
    word        = 18'h0_0000;
    if (bck_rise) begin
      shift_next = nshift;
      lr_next    = s2_reg[I_LRCK];
      if (i2s_reg) begin
        // MSB one bit clock after the frame clock edge, low half is left
        if (s2_reg[I_LRCK] != lr_reg) begin
          cnt_next = 6'h00;
        end else if (cnt_reg != 6'h3F) begin
          cnt_next = cnt_reg + 6'h01;
        end
        if (s2_reg[I_LRCK] == lr_reg && cnt_reg + 6'h01 == len) begin
          word_done = 1'b1;
          word_left = ~s2_reg[I_LRCK];
          word      = align(l18_reg, nshift);
        end
      end else if (s2_reg[I_LRCK] != lr_reg) begin
        // LSB is the last bit before the edge, high half is left
        word_done = 1'b1;
        word_left = lr_reg;
        word      = align(l18_reg, shift_reg);
      end
      if (word_done && word_left) begin
        lhold_next = word;
      end else if (word_done) begin
        left_next   = lhold_reg;
        right_next  = word;
        strobe_next = 1'b1;
      end
      if (s2_reg[I_DAT]) begin
        zrun_next = '0;
      end else if (zrun_reg != ZW'(ZERO_RUN)) begin
        zrun_next = zrun_reg + 1'b1;
      end
      sil_next = (zrun_next == ZW'(ZERO_RUN));
    end
    if (soft_rst) begin
      shift_next  = 18'h0_0000;
      cnt_next    = 6'h00;
      lhold_next  = 18'h0_0000;
      left_next   = 18'h0_0000;
      right_next  = 18'h0_0000;
      strobe_next = 1'b0;
      zrun_next   = '0;
      sil_next    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg  <= 18'h0_0000;
      cnt_reg    <= 6'h00;
      lr_reg     <= 1'b0;
      lhold_reg  <= 18'h0_0000;
      left_reg   <= 18'h0_0000;
      right_reg  <= 18'h0_0000;
      strobe_reg <= 1'b0;
      zrun_reg   <= '0;
      sil_reg    <= 1'b0;
    end else begin
      shift_reg  <= shift_next;
      cnt_reg    <= cnt_next;
      lr_reg     <= lr_next;
      lhold_reg  <= lhold_next;
      left_reg   <= left_next;
      right_reg  <= right_next;
      strobe_reg <= strobe_next;
      zrun_reg   <= zrun_next;
      sil_reg    <= sil_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode pins and serial control port
  always_comb begin
    cw_next   = cw_reg;
    fmt_next  = fmt_reg;
    dm_next   = dm_reg;
    swm_next  = s2_reg[I_MODE];
    bosc_next = s2_reg[I_OSC];
    if (s2_reg[I_MODE]) begin
      if (csh_rise) begin
        cw_next = {cw_reg[14:0], s2_reg[I_P0]};
      end
      if (lat_rise) begin
        if (cw_reg[CW_IDX_LSB +: 2] == CW_REG_FMT) begin
          fmt_next = cw_reg[1:0];
        end else if (cw_reg[CW_IDX_LSB +: 2] == CW_REG_DEEMPH) begin
          dm_next = cw_reg[2:0];
        end
      end
      i2s_next  = fmt_reg[FMT_I2S_BIT];
      l18_next  = fmt_reg[FMT_LEN18_BIT];
      de_next   = dm_reg[1:0];
      mute_next = dm_reg[DM_MUTE_BIT] | sil_reg;
    end else begin
      i2s_next  = 1'b0;
      l18_next  = 1'b0;
      de_next   = {s2_reg[I_P1], s2_reg[I_P0]};
      mute_next = ~s2_reg[I_P2] | sil_reg;
    end
    if (soft_rst) begin
      cw_next  = 16'h0000;
      fmt_next = 2'h0;
      dm_next  = 3'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cw_reg   <= 16'h0000;
      fmt_reg  <= 2'h0;
      dm_reg   <= 3'h0;
      swm_reg  <= 1'b0;
      i2s_reg  <= 1'b0;
      l18_reg  <= 1'b0;
      de_reg   <= 2'h0;
      mute_reg <= 1'b0;
      bosc_reg <= 1'b0;
    end else begin
      cw_reg   <= cw_next;
      fmt_reg  <= fmt_next;
      dm_reg   <= dm_next;
      swm_reg  <= swm_next;
      i2s_reg  <= i2s_next;
      l18_reg  <= l18_next;
      de_reg   <= de_next;
      mute_reg <= mute_next;
      bosc_reg <= bosc_next;
    end
  end

  // Open drain: only ever pulls low, enable follows the zero mute
  assign link.silence_o       = 1'b0;
  assign link.silence_oe      = sil_reg;
  assign link.buffered_osc_out = bosc_reg;
  assign left_sample          = left_reg;
  assign right_sample         = right_reg;
  assign sample_strobe        = strobe_reg;
  assign sw_mode              = swm_reg;
  assign i2s_mode             = i2s_reg;
  assign word_len18           = l18_reg;
  assign deemph_sel           = de_reg;
  assign mute                 = mute_reg;
endmodule

// file: sdac_properties.sv
// Purpose: Link assertions for the two joined stereo DAC ends
// Assumes: ZERO_RUN matches the DAC end
// Notes:   Counters run on raw pins, so they lead the DAC by a few cycles
`timescale 1ns/10ps
module sdac_properties
  import sdac_pkg::*;
#(
  parameter int ZERO_RUN = ZERO_RUN_BCK
)(
  // System
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link
  input wire logic frame_sync_clock,
  input wire logic bit_clock_in,
  input wire logic audio_data,
  input wire logic osc_in,
  input wire logic ext_reset_n,
  input wire logic buffered_osc_out,
  input wire logic silence_o,
  input wire logic silence_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic bck_reg, fs_reg, seen_reg, seen_next;
  int   zrun_reg, zrun_next, slot_reg, slot_next;
  //////////////////////////////////////////////////////////////////
  // First half after a restart may be partial, so it is not judged
  always_comb begin
    zrun_next = ext_reset_n ? zrun_reg : 0;
    slot_next = slot_reg;
    seen_next = seen_reg && ext_reset_n;
    if (bit_clock_in && !bck_reg) begin
      zrun_next = audio_data ? 0 : zrun_next + 1;
      slot_next = slot_reg + 1;
    end
    if (frame_sync_clock != fs_reg) begin
      slot_next = 0;
      seen_next = ext_reset_n;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bck_reg  <= 1'b0;
      fs_reg   <= 1'b0;
      seen_reg <= 1'b0;
      zrun_reg <= 0;
      slot_reg <= 0;
    end else begin
      bck_reg  <= bit_clock_in;
      fs_reg   <= frame_sync_clock;
      seen_reg <= seen_next;
      zrun_reg <= zrun_next;
      slot_reg <= slot_next;
    end
  end
  //////////////////////////////////////////////////////////////////
  sequence bck_high_phase;
    bit_clock_in [*4] ##1 !bit_clock_in;
  endsequence
  chk_bck_half: assert property (disable iff (!rst_n || !ext_reset_n)
    $rose(bit_clock_in) |-> bck_high_phase) else $error("bit clock high phase wrong");
  chk_data_fall: assert property ($changed(audio_data) && $past(ext_reset_n)
    |-> $fell(bit_clock_in)) else $error("data moved off a bit clock fall");
  chk_frame_fall: assert property ($changed(frame_sync_clock) && $past(ext_reset_n)
    |-> $fell(bit_clock_in)) else $error("frame clock moved off a bit clock fall");
  chk_half_slots: assert property ($changed(frame_sync_clock) && seen_reg
    |-> slot_reg == SLOTS_PER_HALF) else $error("half frame bit count wrong");
  chk_osc_copy: assert property (buffered_osc_out == $past(osc_in, 3))
    else $error("clock output not a copy of oscillator");
  chk_drain_only: assert property (silence_oe |-> !silence_o)
    else $error("silence flag driven high");
  chk_flag_late: assert property ($rose(silence_oe) |-> zrun_reg >= ZERO_RUN)
    else $error("silence flag before zero run complete");
  chk_flag_prompt: assert property (zrun_reg == ZERO_RUN + 2 |-> silence_oe)
    else $error("silence flag missing after zero run");
  chk_flag_release: assert property ($rose(bit_clock_in) && audio_data
    |-> ##[1:6] !silence_oe) else $error("silence flag kept after a one bit");
endmodule

// file: tb.sv
// Purpose: Self-checking bench, source and DAC ends joined back to back
// Assumes: 20 MHz ref_clk, zero run shortened to 32 bit clocks
// Notes:   A frame is 512 cycles, so strobe waits are bounded near two frames, the silence wait near five
`timescale 1ns/10ps
module tb
  import sdac_pkg::*;
;
  // Longer than any zero run inside the rj16 and i2s18 test words, so only silence or left 1 over right 0 trips it
  localparam int ZR = 32;
  logic        ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
  logic        irq, sample_strobe, sw_mode, i2s_mode, word_len18, mute;
  logic [17:0] left_sample, right_sample;
  logic [1:0]  deemph_sel;
  int          fails = 0, checks = 0;
  sdac_if link ();
  sdac_src i_sdac_src (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  sdac_dev #(.ZERO_RUN(ZR)) i_sdac_dev (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .left_sample(left_sample), .right_sample(right_sample), .sample_strobe(sample_strobe),
    .sw_mode(sw_mode), .i2s_mode(i2s_mode), .word_len18(word_len18), .deemph_sel(deemph_sel),
    .mute(mute));
  sdac_properties #(.ZERO_RUN(ZR)) i_sdac_properties (.ref_clk(ref_clk), .rst_n(rst_n),
    .frame_sync_clock(link.frame_sync_clock), .bit_clock_in(link.bit_clock_in),
    .audio_data(link.audio_data), .osc_in(link.osc_in), .ext_reset_n(link.ext_reset_n),
    .buffered_osc_out(link.buffered_osc_out), .silence_o(link.silence_o),
    .silence_oe(link.silence_oe));
  //////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Every wait is bounded; running out ends the run at once
  task automatic wait_for(ref logic s, input logic v, input int n);
    checks++;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      if (s === v) return;
    end
    fails++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic frames();
    repeat (3) wait_for(sample_strobe, 1'b1, 1200);
  endtask
  //////////////////////////////////////////////////////////////////
  task automatic t_rj16();
    wr(ADDR_LEFT, 32'h0000_8001);
    wr(ADDR_RIGHT, 32'h0000_7FFE);
    wr(ADDR_CTRL, 32'h0000_0001);
    frames();
    check(left_sample, {16'h8001, 2'h0}, "rj left");
    check(right_sample, {16'h7FFE, 2'h0}, "rj right");
    $display("rj16 done");
  endtask
  task automatic t_hw();
    wr(ADDR_CTRL, 32'h0000_0065);
    repeat (8) @(posedge ref_clk);
    #1;
    check({sw_mode, word_len18, deemph_sel, mute}, 5'h06, "hw pins");
    wr(ADDR_CTRL, 32'h0000_00E5);
    repeat (8) @(posedge ref_clk);
    #1;
    check({link.ctrl_latch_strobe, mute}, 2'h1, "pin mute");
    $display("hw done");
  endtask
  task automatic t_silence();
    wr(ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_MASK, 32'h0000_0004);
    wr(ADDR_LEFT, 32'h0000_0000);
    wr(ADDR_RIGHT, 32'h0000_0000);
    rd(ADDR_STATUS);
    wait_for(link.silence_line, 1'b0, 2500);
    @(posedge ref_clk);
    #1;
    check(mute, 1'b1, "zero mute");
    wait_for(irq, 1'b1, 4);
    rd(ADDR_STATUS);
    check(d[ST_SILENCE], 1'b1, "silence status");
    wait_for(irq, 1'b0, 3);
    wr(ADDR_LEFT, 32'h0000_0001);
    wait_for(link.silence_line, 1'b1, 1200);
    wait_for(mute, 1'b0, 4);
    $display("silence done");
  endtask
  task automatic t_regs();
    rd(8'hFC);
    check(d, 32'h0000_0000, "unmapped read");
    wr(ADDR_MASK, 32'h0000_0000);
    rd(ADDR_STATUS);
    repeat (600) @(posedge ref_clk);
    #1;
    check(irq, 1'b0, "masked irq");
    rd(ADDR_STATUS);
    check(d[ST_FRAME], 1'b1, "frame status");
    wr(ADDR_MASK, 32'h0000_0001);
    wait_for(irq, 1'b1, 600);
    $display("regs done");
  endtask
  task automatic t_i2s18();
    wr(ADDR_CTRL, 32'h0000_001E);
    wr(ADDR_CTRL, 32'h0000_000E);
    wr(ADDR_CMD, 32'h0000_0303);
    d = 32'h0000_0000;
    for (int i = 0; i < 200 && d[ST_CMD] !== 1'b1; i++) rd(ADDR_STATUS);
    check(d[ST_CMD], 1'b1, "command done");
    wr(ADDR_CMD, 32'h0000_0202);
    d = 32'h0000_0000;
    for (int i = 0; i < 200 && d[ST_CMD] !== 1'b1; i++) rd(ADDR_STATUS);
    check({d[ST_CMD], deemph_sel}, 3'h6, "sw deemph");
    wr(ADDR_LEFT, 32'h0002_0001);
    wr(ADDR_RIGHT, 32'h0001_FFFE);
    wr(ADDR_CTRL, 32'h0000_000F);
    frames();
    check({link.op_mode_sel, sw_mode, i2s_mode, word_len18}, 4'hF, "sw format");
    check(left_sample, 18'h2_0001, "i2s left");
    check(right_sample, 18'h1_FFFE, "i2s right");
    $display("i2s18 done");
  endtask
  // Ext reset comes from the source, so it must clear the learned format
  task automatic t_reset();
    wr(ADDR_CTRL, 32'h0000_001E);
    repeat (6) @(posedge ref_clk);
    #1;
    check({i2s_mode, word_len18, left_sample}, 20'h0_0000, "ext reset");
    $display("reset done");
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_rj16();
    t_hw();
    t_silence();
    t_regs();
    t_i2s18();
    t_reset();
    complete_run();
  end
endmodule
